// File: ipfc_core.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Four stages fetch, decode, execute, writeback retire strictly in order.
// - Prefetch buffer holds two words, feeding one instruction per cycle.
// - Compressed halfword instructions are expanded to 32-bit form in fetch.
// - Jumps resolve in decode, flush fetch and request target same cycle.
// - Jump costs two cycles, three for misaligned 32-bit target.
// - Taken branch from execute flushes fetch and decode; not-taken costs one.
// - Execute results forward into decode operands with no stall.
// - Use of a load result right after the load stalls one cycle.
// - Register jump using previous result stalls one cycle.
// - Use right after FPU op stalls its latency; divide or sqrt longer.
// - FPU latency zero or above one owns execute port except listed cases.
// - FPU latency one writes via load port; load wins conflicts.
// - Plain multiply takes one cycle, upper-word multiply five.
// - Divide takes three to thirty-five cycles by divisor leading zeros.
// - Aligned access one cycle; misaligned two; event load four.
// - Slow control registers take four cycles, others one.
// - Instruction fence acts as jump to next instruction.
// - Non-FPU instructions issue past outstanding FPU op unless conflicting.
// - Word-aligned fetches go into a two-entry FIFO, may overrun code.
// - Request and address held stable until grant.
// - Fetch port is read-only.
// - Outstanding requests limited to FIFO depth, no identifiers.
// - Spanning instructions use two aligned fetches; address bit zero ignored.
module ipfc_core
	import ipfc_pkg::*;
#(
	parameter int unsigned DEPTH = IPFC_FIFO_DEPTH,
	parameter logic [5:0] FPU_LATENCY = 6'h00
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	output logic fetch_request_o,
	output logic [31:0] fetch_address_o,
	input wire logic fetch_grant_i,
	input wire logic fetch_response_valid_i,
	input wire logic [31:0] fetch_read_word_i,
	input wire ipfc_pkg::ipfc_op_e id_op_i,
	input wire logic [4:0] id_rs1_i,
	input wire logic [4:0] id_rs2_i,
	input wire logic [4:0] id_rd_i,
	input wire logic [31:0] id_target_i,
	input wire logic ex_branch_taken_i,
	input wire logic [31:0] ex_target_i,
	input wire logic [31:0] ex_divisor_i,
	input wire logic ex_misaligned_i,
	input wire logic ex_post_inc_i,
	input wire logic ex_csr_slow_i,
	input wire logic fpu_result_valid_i,
	input wire logic wb_load_valid_i,
	output logic [31:0] id_instr_o,
	output logic [31:0] id_pc_o,
	output logic id_valid_o,
	output logic ex_valid_o,
	output logic wb_valid_o,
	output logic ex_forward_o,
	output logic id_stall_o,
	output logic ex_busy_o,
	output logic fpu_wr_ex_port_o,
	output logic fpu_wr_wb_port_o,
	output logic fpu_result_held_o
);
	localparam int unsigned CW = $clog2(DEPTH+1);
	////////////////////////////////////////////////////////////
	// Fetch state
	ipfc_fs_e fs_q;
	logic [31:0] pc_q;
	logic [CW-1:0] outst_q;
	logic [CW-1:0] drop_q;
	logic [CW-1:0] outst_d;
	logic wait_gnt;
	logic [CW-1:0] fifo_cnt;
	logic [31:0] fifo_head;
	logic [31:0] fifo_next;
	logic [31:0] exp_instr;
	logic [15:0] half_sel;
	logic is_rvc;
	logic have_instr;
	logic take_instr;
	logic fifo_pop;
	logic push;
	logic flush;
	logic [31:0] flush_pc;
	logic [31:0] instr_raw;
	logic can_issue;
	logic jump_id;
	logic hazard;
	logic ex_hold;
	logic [5:0] ex_cnt_q;
	logic [5:0] fpu_cnt_q;
	logic [4:0] fpu_rd_q;
	ipfc_op_e ex_op_q;
	logic [4:0] ex_rd_q;

	function automatic logic [5:0] ipfc_lead_zero(input logic [31:0] v);
		ipfc_lead_zero = 6'h20;
		for (int i = 0; i < 32; i++) begin
			if (v[i]) ipfc_lead_zero = 6'(31 - i);
		end
	endfunction

	////////////////////////////////////////////////////////////
	// Prefetch buffer and fetch bus
	ipfc_fifo #(
		.DEPTH(DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.flush_i(flush),
		.push_i(push),
		.push_data_i(fetch_read_word_i),
		.pop_i(fifo_pop),
		.head_o(fifo_head),
		.next_o(fifo_next),
		.count_o(fifo_cnt)
	);
	assign push = fetch_response_valid_i && (drop_q == '0) && !flush;
	assign can_issue = (CW'(fifo_cnt + outst_q) < CW'(DEPTH));
	assign outst_d = outst_q + CW'(fetch_request_o && fetch_grant_i) - CW'(fetch_response_valid_i);
	// Grant of a request left over from a flush
	assign wait_gnt = (fs_q == IPFC_FS_WAIT) && fetch_grant_i;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			outst_q <= '0;
		end else begin
			outst_q <= outst_d;
		end
	end
	// Responses still in flight at a flush are discarded
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			drop_q <= '0;
		end else if (flush) begin
			drop_q <= outst_d;
		end else begin
			drop_q <= drop_q + CW'(wait_gnt) - CW'(fetch_response_valid_i && drop_q != '0);
		end
	end
	// Request held with stable address until grant; read-only port
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fs_q <= IPFC_FS_IDLE;
			fetch_request_o <= 1'b0;
			fetch_address_o <= IPFC_RESET_PC;
		end else begin
			case (fs_q)
				IPFC_FS_IDLE: begin
					fs_q <= IPFC_FS_RUN;
					fetch_request_o <= 1'b1;
				end
				IPFC_FS_RUN: begin
					if (flush && (!fetch_request_o || fetch_grant_i)) begin
						fetch_address_o <= {flush_pc[31:2], 2'h0};
						fetch_request_o <= (outst_d < CW'(DEPTH));
					end else if (flush) begin
						fs_q <= IPFC_FS_WAIT;
					end else if (!fetch_request_o || fetch_grant_i) begin
						if (fetch_request_o) fetch_address_o <= fetch_address_o + IPFC_WORD_STEP;
						fetch_request_o <= fetch_request_o ? (CW'(fifo_cnt + outst_q + 1'b1) < CW'(DEPTH))
							: can_issue;
					end
				end
				IPFC_FS_WAIT: begin
					if (fetch_grant_i) begin
						fs_q <= IPFC_FS_RUN;
						fetch_address_o <= flush ? {flush_pc[31:2], 2'h0} : {pc_q[31:2], 2'h0};
						fetch_request_o <= (outst_d < CW'(DEPTH));
					end
				end
				default: fs_q <= IPFC_FS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// Aligner and expander
	assign half_sel = pc_q[1] ? fifo_head[31:16] : fifo_head[15:0];
	assign is_rvc = (half_sel[1:0] != IPFC_RVC_FULL);
	// Misaligned 32-bit instructions need both buffered words
	assign have_instr = (fs_q == IPFC_FS_RUN) && (fifo_cnt != '0) &&
		(is_rvc || !pc_q[1] || fifo_cnt > CW'(1));
	assign instr_raw = pc_q[1] ? {fifo_next[15:0], fifo_head[31:16]} : fifo_head;
	ipfc_rvc_expand u_rvc (
		.half_i(half_sel),
		.instr_o(exp_instr)
	);
	// Decode holds its instruction while stalled
	assign take_instr = have_instr && (!id_valid_o || !hazard) && !flush;
	assign fifo_pop = take_instr && (pc_q[1] || !is_rvc);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pc_q <= IPFC_RESET_PC;
		end else if (flush) begin
			pc_q <= {flush_pc[31:1], 1'b0};
		end else if (take_instr) begin
			pc_q <= pc_q + (is_rvc ? IPFC_HALF_STEP : IPFC_WORD_STEP);
		end
	end

	////////////////////////////////////////////////////////////
	// Decode stage
	assign jump_id = id_valid_o && !hazard &&
		(id_op_i == IPFC_OP_JUMP || id_op_i == IPFC_OP_JALR || id_op_i == IPFC_OP_FENCEI);
	assign flush = (ex_valid_o && ex_branch_taken_i && ex_op_q == IPFC_OP_BRANCH) || jump_id;
	assign flush_pc = (ex_valid_o && ex_branch_taken_i && ex_op_q == IPFC_OP_BRANCH) ? ex_target_i
		: (id_op_i == IPFC_OP_FENCEI) ? id_pc_o + IPFC_WORD_STEP : id_target_i;
	// Hazard detection
	always_comb begin
		hazard = 1'b0;
		if (id_valid_o && ex_valid_o && ex_rd_q != 5'h00 &&
			(ex_rd_q == id_rs1_i || ex_rd_q == id_rs2_i)) begin
			if (ex_op_q == IPFC_OP_LOAD || ex_op_q == IPFC_OP_ELW) hazard = 1'b1;
			if (id_op_i == IPFC_OP_JALR && ex_rd_q == id_rs1_i) hazard = 1'b1;
		end
		if (id_valid_o && fpu_cnt_q != 6'h00 && fpu_rd_q != 5'h00 &&
			(fpu_rd_q == id_rs1_i || fpu_rd_q == id_rs2_i || fpu_rd_q == id_rd_i)) begin
			hazard = 1'b1;
		end
		if (ex_hold) hazard = 1'b1;
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			id_stall_o <= 1'b0;
		end else begin
			id_stall_o <= hazard;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			id_valid_o <= 1'b0;
			id_instr_o <= IPFC_NOP;
			id_pc_o <= IPFC_RESET_PC;
		end else if (flush) begin
			id_valid_o <= 1'b0;
		end else if (take_instr) begin
			id_valid_o <= 1'b1;
			id_instr_o <= is_rvc ? exp_instr : instr_raw;
			id_pc_o <= pc_q;
		end else if (!hazard) begin
			id_valid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////
	// Execute stage with multi-cycle occupancy
	assign ex_hold = ex_valid_o && ex_cnt_q > IPFC_CYC_ONE;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ex_valid_o <= 1'b0;
			ex_op_q <= IPFC_OP_ALU;
			ex_rd_q <= 5'h00;
			ex_cnt_q <= 6'h00;
		end else if (ex_hold) begin
			ex_cnt_q <= ex_cnt_q - IPFC_CYC_ONE;
		end else if (id_valid_o && !hazard && !flush) begin
			ex_valid_o <= 1'b1;
			ex_op_q <= id_op_i;
			ex_rd_q <= id_rd_i;
			case (id_op_i)
				IPFC_OP_MULH: ex_cnt_q <= IPFC_CYC_MULH;
				IPFC_OP_DIV: ex_cnt_q <= IPFC_CYC_DIV_MIN + ipfc_lead_zero(ex_divisor_i);
				IPFC_OP_LOAD, IPFC_OP_STORE: ex_cnt_q <= ex_misaligned_i ? IPFC_CYC_MISALIGN : IPFC_CYC_ONE;
				IPFC_OP_ELW: ex_cnt_q <= IPFC_CYC_ELW;
				IPFC_OP_CSR: ex_cnt_q <= ex_csr_slow_i ? IPFC_CYC_CSR_SLOW : IPFC_CYC_ONE;
				default: ex_cnt_q <= IPFC_CYC_ONE;
			endcase
		end else begin
			ex_valid_o <= 1'b0;
			ex_cnt_q <= 6'h00;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ex_busy_o <= 1'b0;
			ex_forward_o <= 1'b0;
		end else begin
			ex_busy_o <= ex_hold;
			ex_forward_o <= ex_valid_o && !ex_hold && ex_rd_q != 5'h00 &&
				ex_op_q inside {IPFC_OP_ALU, IPFC_OP_MUL, IPFC_OP_MULH, IPFC_OP_DIV};
		end
	end
	// Writeback follows execute in order
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wb_valid_o <= 1'b0;
		end else begin
			wb_valid_o <= ex_valid_o && !ex_hold;
		end
	end

	////////////////////////////////////////////////////////////
	// FPU scoreboard and write port arbitration
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fpu_cnt_q <= 6'h00;
			fpu_rd_q <= 5'h00;
		end else if (id_valid_o && !hazard && !flush &&
			(id_op_i == IPFC_OP_FPU || id_op_i == IPFC_OP_FDIV)) begin
			fpu_cnt_q <= (id_op_i == IPFC_OP_FDIV) ? IPFC_CYC_DIV_MAX : FPU_LATENCY;
			fpu_rd_q <= id_rd_i;
		end else if (fpu_result_valid_i) begin
			fpu_cnt_q <= 6'h00;
		end else if (fpu_cnt_q != 6'h00) begin
			fpu_cnt_q <= fpu_cnt_q - IPFC_CYC_ONE;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fpu_wr_ex_port_o <= 1'b0;
			fpu_wr_wb_port_o <= 1'b0;
			fpu_result_held_o <= 1'b0;
		end else if (FPU_LATENCY == IPFC_CYC_ONE) begin
			fpu_wr_ex_port_o <= 1'b0;
			fpu_wr_wb_port_o <= (fpu_result_valid_i || fpu_result_held_o) && !wb_load_valid_i;
			fpu_result_held_o <= (fpu_result_valid_i || fpu_result_held_o) && wb_load_valid_i;
		end else begin
			fpu_wr_wb_port_o <= 1'b0;
			if ((fpu_result_valid_i || fpu_result_held_o) && ex_valid_o &&
				(ex_op_q == IPFC_OP_MULH || ex_misaligned_i || ex_post_inc_i)) begin
				fpu_wr_ex_port_o <= 1'b0;
				fpu_result_held_o <= 1'b1;
			end else begin
				fpu_wr_ex_port_o <= fpu_result_valid_i || fpu_result_held_o;
				fpu_result_held_o <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: ipfc_pkg.sv
package ipfc_pkg;
	localparam int unsigned IPFC_XLEN = 32;
	localparam int unsigned IPFC_FIFO_DEPTH = 2;
	localparam int unsigned IPFC_CNT_W = 6;
	localparam logic [31:0] IPFC_RESET_PC = 32'h0000_0000;
	localparam logic [31:0] IPFC_NOP = 32'h0000_0013;
	localparam logic [31:0] IPFC_WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] IPFC_HALF_STEP = 32'h0000_0002;
	localparam logic [1:0] IPFC_RVC_FULL = 2'h3;
	// Total execute cycles taken by multi-cycle work
	localparam logic [5:0] IPFC_CYC_MULH = 6'h05;
	localparam logic [5:0] IPFC_CYC_DIV_MIN = 6'h03;
	localparam logic [5:0] IPFC_CYC_DIV_MAX = 6'h23;
	localparam logic [5:0] IPFC_CYC_MISALIGN = 6'h02;
	localparam logic [5:0] IPFC_CYC_ELW = 6'h04;
	localparam logic [5:0] IPFC_CYC_CSR_SLOW = 6'h04;
	localparam logic [5:0] IPFC_CYC_ONE = 6'h01;
	// Instruction class from the decoder
	typedef enum logic [3:0] {
		IPFC_OP_ALU = 4'h0,
		IPFC_OP_MUL = 4'h1,
		IPFC_OP_MULH = 4'h2,
		IPFC_OP_DIV = 4'h3,
		IPFC_OP_LOAD = 4'h4,
		IPFC_OP_STORE = 4'h5,
		IPFC_OP_ELW = 4'h6,
		IPFC_OP_CSR = 4'h7,
		IPFC_OP_JUMP = 4'h8,
		IPFC_OP_JALR = 4'h9,
		IPFC_OP_BRANCH = 4'ha,
		IPFC_OP_FENCEI = 4'hb,
		IPFC_OP_FPU = 4'hc,
		IPFC_OP_FDIV = 4'hd
	} ipfc_op_e;
	typedef enum logic [1:0] {
		IPFC_FS_IDLE = 2'b00,
		IPFC_FS_RUN = 2'b01,
		IPFC_FS_WAIT = 2'b11
	} ipfc_fs_e;
endpackage

// File: ipfc_rvc_expand.sv
`timescale 1ns/100ps
`default_nettype none
module ipfc_rvc_expand
	import ipfc_pkg::*;
(
	input wire logic [15:0] half_i,
	output logic [31:0] instr_o
);
	always_comb begin
		instr_o = IPFC_NOP;
		case ({half_i[15:13], half_i[1:0]})
			5'h00: instr_o = {2'h0, half_i[10:7], half_i[12:11], half_i[5], half_i[6], 2'h0, 5'h02, 3'h0,
				2'h1, half_i[4:2], 7'h13};
			5'h01: instr_o = {{7{half_i[12]}}, half_i[6:2], half_i[11:7], 3'h0, half_i[11:7], 7'h13};
			5'h08: instr_o = {5'h00, half_i[5], half_i[12:10], half_i[6], 2'h0, 2'h1, half_i[9:7], 3'h2,
				2'h1, half_i[4:2], 7'h03};
			5'h09: instr_o = {{7{half_i[12]}}, half_i[6:2], 5'h00, 3'h0, half_i[11:7], 7'h13};
			5'h18: instr_o = {5'h00, half_i[5], half_i[12], 2'h1, half_i[4:2], 2'h1, half_i[9:7], 3'h2,
				half_i[11:10], half_i[6], 2'h0, 7'h23};
			5'h12: instr_o = half_i[12] ? {7'h00, half_i[6:2], half_i[11:7], 3'h0, half_i[11:7], 7'h33}
				: {7'h00, half_i[6:2], 5'h00, 3'h0, half_i[11:7], 7'h33};
			default: instr_o = IPFC_NOP;
		endcase
	end
endmodule
`default_nettype wire

// File: ipfc_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module ipfc_fifo
	import ipfc_pkg::*;
#(
	parameter int unsigned DEPTH = IPFC_FIFO_DEPTH
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [31:0] push_data_i,
	input wire logic pop_i,
	output logic [31:0] head_o,
	output logic [31:0] next_o,
	output logic [$clog2(DEPTH+1)-1:0] count_o
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [31:0] mem_q [DEPTH];
	logic [AW-1:0] rd_q;
	logic [AW-1:0] wr_q;
	function automatic logic [AW-1:0] ipfc_inc(input logic [AW-1:0] p);
		ipfc_inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction
	assign head_o = mem_q[rd_q];
	assign next_o = mem_q[ipfc_inc(rd_q)];
	// Storage only; no reset needed
	always_ff @(posedge clk_i) begin
		if (push_i) begin
			mem_q[wr_q] <= push_data_i;
		end
	end
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_q <= '0;
			wr_q <= '0;
			count_o <= '0;
		end else if (flush_i) begin
			rd_q <= '0;
			wr_q <= '0;
			count_o <= '0;
		end else begin
			if (push_i) wr_q <= ipfc_inc(wr_q);
			if (pop_i) rd_q <= ipfc_inc(rd_q);
			count_o <= count_o + (push_i ? 1'b1 : 1'b0) - (pop_i ? 1'b1 : 1'b0);
		end
	end
endmodule
`default_nettype wire

// File: ipfc_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ipfc_core_checker
	import ipfc_pkg::*;
#(
	parameter int unsigned DEPTH = IPFC_FIFO_DEPTH,
	parameter logic [5:0] FPU_LATENCY = 6'h00
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic fetch_request_o,
	input wire logic [31:0] fetch_address_o,
	input wire logic fetch_grant_i,
	input wire logic fetch_response_valid_i,
	input wire ipfc_pkg::ipfc_op_e id_op_i,
	input wire logic [31:0] id_target_i,
	input wire logic ex_branch_taken_i,
	input wire logic id_valid_o,
	input wire logic ex_valid_o,
	input wire logic wb_valid_o,
	input wire logic ex_busy_o,
	input wire logic fpu_wr_wb_port_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [2:0] out_q;
	logic [1:0] rc_q;
	logic [31:0] tgt_q;
	////////////////////////////////
	// Outstanding fetches
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) out_q <= 3'h0;
		else out_q <= out_q + 3'(fetch_request_o && fetch_grant_i) - 3'(fetch_response_valid_i);
	end
	// Cycles since reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) rc_q <= 2'h0;
		else if (rc_q != 2'h3) rc_q <= rc_q + 2'h1;
	end
	always_ff @(posedge clk_i) begin
		tgt_q <= id_target_i;
	end
	////////////////////////////////
	sequence s_jump_taken;
		id_valid_o && id_op_i == IPFC_OP_JUMP && !ex_busy_o && !(fetch_request_o && !fetch_grant_i)
			&& !(ex_valid_o && ex_branch_taken_i) ##1 !id_valid_o;
	endsequence
	sequence s_retarget;
		fetch_address_o == {tgt_q[31:2], 2'h0};
	endsequence
	property p_req_hold;
		fetch_request_o && !fetch_grant_i |=> fetch_request_o && $stable(fetch_address_o);
	endproperty
	property p_addr_align;
		fetch_request_o |-> fetch_address_o[1:0] == 2'h0;
	endproperty
	property p_outstanding;
		out_q <= DEPTH;
	endproperty
	property p_ex_order;
		$rose(ex_valid_o) |-> $past(id_valid_o);
	endproperty
	property p_wb_order;
		$rose(wb_valid_o) |-> $past(ex_valid_o);
	endproperty
	property p_fpu_wb_port;
		FPU_LATENCY != 6'h01 |-> !fpu_wr_wb_port_o;
	endproperty
	property p_jump_retarget;
		s_jump_taken |-> s_retarget;
	endproperty
	property p_reset_start;
		rc_q == 2'h2 |-> fetch_request_o && fetch_address_o == IPFC_RESET_PC;
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("fetch request moved before grant");
	a_addr_align: assert property (p_addr_align) else $error("fetch address not word aligned");
	a_outstanding: assert property (p_outstanding) else $error("too many outstanding fetches");
	a_ex_order: assert property (p_ex_order) else $error("execute filled without decode");
	a_wb_order: assert property (p_wb_order) else $error("writeback filled without execute");
	a_fpu_wb_port: assert property (p_fpu_wb_port) else $error("fpu used load port");
	a_jump_retarget: assert property (p_jump_retarget) else $error("jump did not retarget fetch");
	a_reset_start: assert property (p_reset_start) else $error("no first fetch at reset pc");
endmodule
bind ipfc_core ipfc_core_checker #(.DEPTH(DEPTH), .FPU_LATENCY(FPU_LATENCY)) ipfc_core_checker_i (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .fetch_request_o(fetch_request_o), .fetch_address_o(fetch_address_o),
	.fetch_grant_i(fetch_grant_i), .fetch_response_valid_i(fetch_response_valid_i), .id_op_i(id_op_i),
	.id_target_i(id_target_i), .ex_branch_taken_i(ex_branch_taken_i), .id_valid_o(id_valid_o),
	.ex_valid_o(ex_valid_o), .wb_valid_o(wb_valid_o), .ex_busy_o(ex_busy_o), .fpu_wr_wb_port_o(fpu_wr_wb_port_o)
);
`default_nettype wire

// File: ipfc_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ipfc_mem_model (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic gstall_i,
	input wire logic rstall_i,
	output logic gnt_o,
	output logic rvalid_o,
	output logic [31:0] rdata_o
);
	logic [31:0] pend_q[$];
	// Read-only port, grant when not stalled
	assign gnt_o = req_i && !gstall_i;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_q.delete();
			rvalid_o <= 1'h0;
			rdata_o <= 32'h0;
		end else begin
			rvalid_o <= 1'h0;
			rdata_o <= ~rdata_o;
			// One pulse per grant, in grant order
			if (pend_q.size() > 0 && !rstall_i) begin
				rvalid_o <= 1'h1;
				rdata_o <= {pend_q[0][26:2], 7'h13};
				void'(pend_q.pop_front());
			end
			if (gnt_o) pend_q.push_back(addr_i);
		end
	end
endmodule
`default_nettype wire

// File: test_inorder_pipeline_fetch_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_inorder_pipeline_fetch_control;
	import ipfc_pkg::*;
	logic clk_i, arst_n_i, gstall, rstall, req, gnt, rvalid, ex_branch_taken_i, ex_misaligned_i;
	logic ex_post_inc_i, ex_csr_slow_i, fpu_result_valid_i, wb_load_valid_i, id_valid_o, ex_busy_o, fpu_ex;
	logic stl, fwd, exv, held;
	logic [31:0] addr, rdata, id_target_i, ex_target_i, ex_divisor_i, id_instr_o, id_pc_o;
	logic [4:0] rs1, rs2, rd;
	ipfc_op_e id_op_i;
	int n_mismatch, n_checks, seed, cyc;
	ipfc_core ipfc_core_i (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .fetch_request_o(req), .fetch_address_o(addr), .fetch_grant_i(gnt),
		.fetch_response_valid_i(rvalid), .fetch_read_word_i(rdata), .id_op_i(id_op_i), .id_rs1_i(rs1),
		.id_rs2_i(rs2), .id_rd_i(rd), .id_target_i(id_target_i), .ex_branch_taken_i(ex_branch_taken_i),
		.ex_target_i(ex_target_i), .ex_divisor_i(ex_divisor_i), .ex_misaligned_i(ex_misaligned_i),
		.ex_post_inc_i(ex_post_inc_i), .ex_csr_slow_i(ex_csr_slow_i), .fpu_result_valid_i(fpu_result_valid_i),
		.wb_load_valid_i(wb_load_valid_i), .id_instr_o(id_instr_o), .id_pc_o(id_pc_o), .id_valid_o(id_valid_o),
		.ex_valid_o(exv), .wb_valid_o(), .ex_forward_o(fwd), .id_stall_o(stl), .ex_busy_o(ex_busy_o),
		.fpu_wr_ex_port_o(fpu_ex), .fpu_wr_wb_port_o(), .fpu_result_held_o(held)
	);
	ipfc_mem_model ipfc_mem_model_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(req), .addr_i(addr),
		.gstall_i(gstall), .rstall_i(rstall), .gnt_o(gnt), .rvalid_o(rvalid), .rdata_o(rdata));
	initial begin
		clk_i = 1'h0;
		forever #25 clk_i = ~clk_i;
	end
	////////////////////////////////
	function automatic logic [31:0] word_of(input logic [31:0] a);
		return {a[26:2], 7'h13};
	endfunction
	// Extra execute cycles per class
	function automatic int hold_of(input ipfc_op_e op, input logic [31:0] dv, input logic mis, input logic slow);
		int z;
		z = 0;
		while (z < 32 && !dv[31 - z]) z++;
		case (op)
			IPFC_OP_MULH: return 4;
			IPFC_OP_DIV: return 2 + z;
			IPFC_OP_LOAD, IPFC_OP_STORE: return mis ? 1 : 0;
			IPFC_OP_ELW: return 3;
			IPFC_OP_CSR: return slow ? 3 : 0;
			default: return 0;
		endcase
	endfunction
	////////////////////////////////
	task automatic tick();
		@(posedge clk_i);
		#2;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset();
		arst_n_i = 1'h0;
		gstall = 1'h1;
		repeat (10) tick();
		check("req_in_reset", 32'(req), 32'h0);
		check("valid_in_reset", 32'(id_valid_o), 32'h0);
		check("instr_in_reset", id_instr_o, IPFC_NOP);
		arst_n_i = 1'h1;
		repeat (3) tick();
		check("first_req", 32'(req), 32'h1);
		check("first_addr", addr, IPFC_RESET_PC);
		gstall = 1'h0;
		$display("test reset done");
	endtask
	task automatic wait_valid();
		int w;
		w = 0;
		while (id_valid_o !== 1'h1 && w < 60) begin
			tick();
			w++;
		end
	endtask
	task automatic run_op(input ipfc_op_e op, input logic [31:0] dv, input logic mis, input logic slow);
		int n;
		int m;
		logic f;
		n = 0;
		m = 0;
		f = 1'h0;
		rs1 = 5'h0;
		rs2 = 5'h0;
		rd = 5'h1;
		wait_valid();
		id_op_i = op;
		ex_divisor_i = dv;
		ex_misaligned_i = mis;
		ex_csr_slow_i = slow;
		tick();
		id_op_i = IPFC_OP_ALU;
		repeat (45) begin
			tick();
			n += (ex_busy_o === 1'h1);
			m += (stl === 1'h1);
			f |= (fwd === 1'h1);
		end
		check("ex_hold", 32'(n), 32'(hold_of(op, dv, mis, slow)));
		check("id_stall", 32'(m), 32'(hold_of(op, dv, mis, slow)));
		check("forward_seen", 32'(f), 32'h1);
	endtask
	task automatic redirect(input ipfc_op_e op, input logic [31:0] t);
		logic [31:0] exp;
		int w;
		wait_valid();
		exp = (op == IPFC_OP_FENCEI) ? id_pc_o + IPFC_WORD_STEP : t;
		id_op_i = op;
		id_target_i = exp;
		tick();
		id_op_i = IPFC_OP_ALU;
		if (op == IPFC_OP_BRANCH) begin
			ex_branch_taken_i = 1'h1;
			ex_target_i = t;
			tick();
			ex_branch_taken_i = 1'h0;
		end
		w = 0;
		while (id_valid_o !== 1'h0 && w < 5) begin
			tick();
			w++;
		end
		wait_valid();
		check("redirect_pc", id_pc_o, exp);
	endtask
	task automatic random_run(input int cycles);
		repeat (cycles) begin
			gstall = ($random(seed) & 3) == 0;
			rstall = ($random(seed) & 3) == 0;
			rs1 = 5'($random(seed));
			rs2 = 5'($random(seed));
			rd = 5'($random(seed));
			wb_load_valid_i = ($random(seed) & 7) == 0;
			tick();
		end
		gstall = 1'h0;
		rstall = 1'h0;
		$display("test stream done");
	endtask
	////////////////////////////////
	// Decode contents against fetched words, and the run ceiling
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end else begin
			#1;
			if (arst_n_i === 1'h1 && id_valid_o === 1'h1) check("id_instr", id_instr_o, word_of(id_pc_o));
		end
	end
	initial begin
		int n;
		seed = 81;
		n_mismatch = 0;
		n_checks = 0;
		cyc = 0;
		arst_n_i = 1'h0;
		gstall = 1'h1;
		rstall = 1'h0;
		id_op_i = IPFC_OP_ALU;
		rs1 = 5'h0;
		rs2 = 5'h0;
		rd = 5'h0;
		id_target_i = 32'h0;
		ex_branch_taken_i = 1'h0;
		ex_target_i = 32'h0;
		ex_divisor_i = 32'h1;
		ex_misaligned_i = 1'h0;
		ex_post_inc_i = 1'h0;
		ex_csr_slow_i = 1'h0;
		fpu_result_valid_i = 1'h0;
		wb_load_valid_i = 1'h0;
		do_reset();
		random_run(300);
		rstall = 1'h1;
		repeat (12) tick();
		rstall = 1'h0;
		run_op(IPFC_OP_ALU, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_MUL, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_MULH, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_DIV, 32'h8000_0000, 1'h0, 1'h0);
		run_op(IPFC_OP_DIV, 32'h0, 1'h0, 1'h0);
		run_op(IPFC_OP_DIV, 32'h1, 1'h0, 1'h0);
		repeat (3) run_op(IPFC_OP_DIV, $random(seed) >> ($random(seed) & 31), 1'h0, 1'h0);
		run_op(IPFC_OP_LOAD, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_LOAD, 32'h1, 1'h1, 1'h0);
		run_op(IPFC_OP_STORE, 32'h1, 1'h1, 1'h0);
		run_op(IPFC_OP_ELW, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_CSR, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_CSR, 32'h1, 1'h0, 1'h1);
		run_op(IPFC_OP_BRANCH, 32'h1, 1'h0, 1'h0);
		run_op(IPFC_OP_FPU, 32'h1, 1'h0, 1'h0);
		$display("test cycle counts done");
		for (int i = 0; i < 4; i++) begin
			redirect(IPFC_OP_JUMP, {20'h0, 10'($random(seed)), 2'h0});
			redirect(IPFC_OP_BRANCH, {20'h0, 10'($random(seed)), 2'h0});
			redirect(IPFC_OP_FENCEI, 32'h0);
		end
		$display("test redirect done");
		ex_post_inc_i = 1'h1;
		while (exv !== 1'h1) tick();
		fpu_result_valid_i = 1'h1;
		tick();
		fpu_result_valid_i = 1'h0;
		check("fpu_held", 32'(held), 32'h1);
		check("fpu_held_ex", 32'(fpu_ex), 32'h0);
		ex_post_inc_i = 1'h0;
		tick();
		check("fpu_late", 32'(fpu_ex), 32'h1);
		fpu_result_valid_i = 1'h1;
		tick();
		fpu_result_valid_i = 1'h0;
		n = 0;
		repeat (6) begin
			n += (fpu_ex === 1'h1);
			tick();
		end
		check("fpu_ex_port", 32'(n), 32'h1);
		$display("test fpu done");
		do_reset();
		random_run(100);
		stop_test();
	end
endmodule
`default_nettype wire
